//--- serial_status_pkg.sv
// Shared constants and carriers for the serial status and interrupt block.
// Assumes a 32-bit AXI4-Lite register bus; each register is one aligned word.
package serial_status_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CH0_CTRL   = 8'h00;
    localparam logic [7:0] IDX_CH1_CTRL   = 8'h01;
    localparam logic [7:0] IDX_CH0_STATUS = 8'h04;
    localparam logic [7:0] IDX_CH1_STATUS = 8'h05;
    localparam logic [7:0] IDX_CH0_TX     = 8'h06;
    localparam logic [7:0] IDX_CH1_TX     = 8'h07;
    localparam logic [7:0] IDX_CH0_RX     = 8'h08;
    localparam logic [7:0] IDX_CH1_RX     = 8'h09;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h0a;
    localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h0b;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h0c;

    // Status register fields
    localparam int BIT_RX_FULL   = 7;
    localparam int BIT_OVERRUN   = 6;
    localparam int BIT_PARITY    = 5;
    localparam int BIT_FRAMING   = 4;
    localparam int BIT_RX_IE     = 3;
    localparam int BIT_PIN       = 2;
    localparam int BIT_TX_EMPTY  = 1;
    localparam int BIT_TX_IE     = 0;

    // Control register fields
    localparam int CTL_MP_EN     = 7;
    localparam int CTL_RX_EN     = 6;
    localparam int CTL_ERR_CLR   = 3;
    localparam int CTL_PARITY_EN = 1;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [1:0] IRQ_RESET    = 2'h0;

    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       parity_bad;
        logic       stop_bit;
        logic       mp_bit;
    } rx_event_t;

    typedef struct packed {
        logic rx_full;
        logic overrun;
        logic parity_error;
        logic framing_error;
    } rx_flags_t;

endpackage : serial_status_pkg

//--- serial_channel_flags.sv
// Receive-side flags and holding register of one serial channel.
// Assumes one-cycle byte-complete pulses from the receive shifter.
`timescale 1ns/1ps
module serial_channel_flags
    import serial_status_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire rx_event_t rx_ev,
    input  wire logic      rx_enable,
    input  wire logic      parity_enable,
    input  wire logic      mp_enable,
    input  wire logic      carrier_high,
    input  wire logic      io_stop,
    input  wire logic      rd_rx,
    input  wire logic      err_clr,
    output rx_flags_t      flags,
    output logic [7:0]     rx_data,
    output logic           mp_bit
);

    rx_flags_t  flags_r;
    rx_flags_t  flags_nxt;
    logic [7:0] rx_data_r;
    logic       mp_bit_r;

    // Disabled receiver drops bytes but keeps flags
    wire accept = rx_ev.valid & rx_enable & (~mp_enable | rx_ev.mp_bit); // RULE_16
    wire land   = accept & ~flags_r.rx_full;
    wire over   = accept & flags_r.rx_full;
    wire flush  = carrier_high | io_stop;

    always_comb begin
        flags_nxt = flags_r;
        if (rd_rx) begin
            flags_nxt.rx_full = 1'b0; // RULE_03
        end
        if (err_clr) begin
            flags_nxt.overrun       = 1'b0; // RULE_05
            flags_nxt.parity_error  = 1'b0;
            flags_nxt.framing_error = 1'b0;
        end
        // Set after read and error clear so a same-cycle event is kept; a flush still wins
        if (land) begin
            flags_nxt.rx_full = 1'b1; // RULE_01 RULE_02
            if (rx_ev.parity_bad && parity_enable) begin
                flags_nxt.parity_error = 1'b1; // RULE_06
            end
            if (!rx_ev.stop_bit) begin
                flags_nxt.framing_error = 1'b1; // RULE_07
            end
        end
        if (over) begin
            flags_nxt.overrun = 1'b1; // RULE_04
        end
        if (flush) begin
            flags_nxt = '0; // RULE_03 RULE_05
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r   <= '0;
            rx_data_r <= 8'h00;
            mp_bit_r  <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            if (land) begin
                rx_data_r <= rx_ev.data; // RULE_02
                mp_bit_r  <= rx_ev.mp_bit;
            end
        end
    end

    assign flags   = flags_r;
    assign rx_data = rx_data_r;
    assign mp_bit  = mp_bit_r;

endmodule : serial_channel_flags

//--- async_serial_status_irq.sv
// Status, interrupt and register logic for a two-channel async serial unit.
// Assumes outside shifters exchange bytes.
// Operation
// (RULE_01) Receive-full flag bit 7 sets when a byte enters the holding register.
// (RULE_02) Bytes with framing or parity errors still load and set receive-full.
// (RULE_03) Receive-full clears on data read, carrier high, I/O stop, reset.
// (RULE_04) Overrun bit 6 sets when a byte completes while holding is full.
// (RULE_05) Error flags clear on error-clear write of 0, carrier high, stop, reset.
// (RULE_06) Parity-error bit 5 sets on bad parity only with parity enabled.
// (RULE_07) Framing-error bit 4 sets when the stop bit samples as 0.
// (RULE_08) Receive enable bit 3 lets any receive flag request an interrupt.
// (RULE_09) Channel 0 also interrupts on a carrier-detect rising edge.
// (RULE_10) Transmit-empty bit 1 is 1 when empty, 0 from write until handoff.
// (RULE_11) Transmit-empty is forced to 1 in I/O stop and during reset.
// (RULE_12) Transmit-empty reads 0 while clear-to-send input is high.
// (RULE_13) Transmit enable bit 0 requests interrupt while empty; reset clears it.
// (RULE_14) Channel 1 bit 2 routes shared pin to clear-to-send or clocked rx.
// (RULE_15) Error-clear bit reads last multiprocessor bit; writing 0 clears errors. Code shows that bit only while bit 7 is set, else 0.
// (RULE_16) Disabled receiver drops bytes but keeps full and error flags.
// (RULE_17) Channel 0 bit 2 shows carrier-detect level and ignores writes.
// (RULE_18) Each channel request ORs enabled receive and transmit conditions.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module async_serial_status_irq
    import serial_status_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Receive shifter events
    input  wire rx_event_t [1:0]    rx_ev,
    // Transmit shifter handoff
    input  wire logic [1:0]         tx_take,
    output logic [1:0]              tx_valid,
    output logic [7:0]              tx_data_ch0,
    output logic [7:0]              tx_data_ch1,
    // Modem and pin lines
    input  wire logic               carrier_detect_ch0,
    input  wire logic               ch0_clear_to_send_input,
    input  wire logic               shared_pin_in,
    output logic                    clocked_serial_rx_pin,
    output logic                    ch1_clear_to_send_input,
    input  wire logic               io_stop_state,
    // Interrupts
    output logic [1:0]              chan_irq,
    output logic                    irq
);

    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
        return addr[9:2];
    endfunction : word_index

    // Write channel state
    logic              aw_hold_r;
    logic [7:0]        aw_idx_r;
    logic              w_hold_r;
    logic [7:0]        wdata_r;
    logic              wstrb0_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    // Read channel state
    logic              rvalid_r;
    logic [7:0]        rdata_r;
    logic [1:0]        rresp_r;

    // Software state
    logic [1:0]        mp_en_r;
    logic [1:0]        rx_en_r;
    logic [1:0]        parity_en_r;
    logic [1:0]        rx_ie_r;
    logic [1:0]        tx_ie_r;
    logic              cts_sel_r;
    logic [1:0]        tx_full_r;
    logic [7:0]        tx_hold_r [2];
    logic              carrier_prev_r;
    logic              carrier_rise_r;
    logic [1:0]        irq_stat_r;
    logic [1:0]        irq_en_r;

    rx_flags_t [1:0]   flags;
    logic [7:0]        rx_data [2];
    logic [1:0]        mp_bit;
    logic [1:0]        cts;
    logic [1:0]        tx_empty;
    logic [7:0]        status_rd [2];
    logic [7:0]        ctrl_rd [2];
    logic [7:0]        rd_val;
    logic              rd_hit;

    // Bus handshakes
    wire wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
    wire ar_fire = s_axi_arvalid & ~rvalid_r;
    wire [7:0] ar_idx = word_index(s_axi_araddr);

    assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
    assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = {24'h000000, rdata_r};

    // Lane 0 carries every register
    wire wr_ok       = wr_fire & wstrb0_r;
    wire wr_ctrl0    = wr_ok & (aw_idx_r == IDX_CH0_CTRL);
    wire wr_ctrl1    = wr_ok & (aw_idx_r == IDX_CH1_CTRL);
    wire wr_serial_ch0_status    = wr_ok & (aw_idx_r == IDX_CH0_STATUS);
    wire wr_serial_ch1_status    = wr_ok & (aw_idx_r == IDX_CH1_STATUS);
    wire wr_tx0      = wr_ok & (aw_idx_r == IDX_CH0_TX);
    wire wr_tx1      = wr_ok & (aw_idx_r == IDX_CH1_TX);
    wire wr_irq_clr  = wr_ok & (aw_idx_r == IDX_IRQ_CLEAR);
    wire wr_irq_en   = wr_ok & (aw_idx_r == IDX_IRQ_ENABLE);
    wire [1:0] wr_ctrl = {wr_ctrl1, wr_ctrl0};
    wire [1:0] wr_stat = {wr_serial_ch1_status, wr_serial_ch0_status};
    wire [1:0] wr_tx   = {wr_tx1, wr_tx0};
    wire wr_known    = (aw_idx_r <= IDX_IRQ_ENABLE) & (aw_idx_r[7:1] != 7'h01);

    // Writing 0 clears errors
    wire [1:0] err_clr = wr_ctrl & {2{~wdata_r[CTL_ERR_CLR]}}; // RULE_15
    wire [1:0] rd_rx   = {2{ar_fire}} & {ar_idx == IDX_CH1_RX, ar_idx == IDX_CH0_RX};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_r <= 1'b0;
            aw_idx_r  <= 8'h00;
            w_hold_r  <= 1'b0;
            wdata_r   <= 8'h00;
            wstrb0_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_idx_r  <= word_index(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r  <= 1'b0;
            end
        end
    end

    // Receive flag logic per channel
    for (genvar c = 0; c < 2; c++) begin : g_chan
        serial_channel_flags u_flags (
            .clk           (clk),
            .rst_n         (rst_n),
            .rx_ev         (rx_ev[c]),
            .rx_enable     (rx_en_r[c]),
            .parity_enable (parity_en_r[c]),
            .mp_enable     (mp_en_r[c]),
            .carrier_high  (carrier_detect_ch0),
            .io_stop       (io_stop_state),
            .rd_rx         (rd_rx[c]),
            .err_clr       (err_clr[c]),
            .flags         (flags[c]),
            .rx_data       (rx_data[c]),
            .mp_bit        (mp_bit[c])
        );
    end

    // Control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mp_en_r     <= CTRL_RESET[CTL_MP_EN] ? 2'h3 : 2'h0;
            rx_en_r     <= CTRL_RESET[CTL_RX_EN] ? 2'h3 : 2'h0;
            parity_en_r <= CTRL_RESET[CTL_PARITY_EN] ? 2'h3 : 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wr_ctrl[c]) begin
                    mp_en_r[c]     <= wdata_r[CTL_MP_EN];
                    rx_en_r[c]     <= wdata_r[CTL_RX_EN];
                    parity_en_r[c] <= wdata_r[CTL_PARITY_EN];
                end
            end
            // Stop mode drops the receivers
            if (io_stop_state) begin
                rx_en_r <= 2'h0;
            end
        end
    end

    // Status enables; channel 0 bit 2 has no storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_ie_r   <= STATUS_RESET[BIT_RX_IE] ? 2'h3 : 2'h0;
            tx_ie_r   <= STATUS_RESET[BIT_TX_IE] ? 2'h3 : 2'h0; // RULE_13
            cts_sel_r <= STATUS_RESET[BIT_PIN];
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wr_stat[c]) begin
                    rx_ie_r[c] <= wdata_r[BIT_RX_IE];
                    tx_ie_r[c] <= wdata_r[BIT_TX_IE];
                end
            end
            if (wr_serial_ch1_status) begin
                cts_sel_r <= wdata_r[BIT_PIN]; // RULE_14
            end
        end
    end

    // Shared pin routing
    assign cts[0]                  = ch0_clear_to_send_input;
    assign cts[1]                  = cts_sel_r & shared_pin_in; // RULE_14
    assign ch1_clear_to_send_input = cts[1];
    // High idle keeps clocked port quiet
    assign clocked_serial_rx_pin   = cts_sel_r | shared_pin_in; // RULE_14

    // Transmit holding registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_full_r    <= 2'h0;
            tx_hold_r[0] <= 8'h00;
            tx_hold_r[1] <= 8'h00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (io_stop_state) begin
                    tx_full_r[c] <= 1'b0; // RULE_11
                end else if (wr_tx[c]) begin
                    tx_full_r[c] <= 1'b1; // RULE_10
                    tx_hold_r[c] <= wdata_r;
                end else if (tx_take[c] && tx_valid[c]) begin
                    tx_full_r[c] <= 1'b0; // RULE_10
                end
            end
        end
    end

    // Handoff waits while clear-to-send is high
    assign tx_valid    = tx_full_r & ~cts;
    assign tx_data_ch0 = tx_hold_r[0];
    assign tx_data_ch1 = tx_hold_r[1];

    // Stop and reset beat clear-to-send
    assign tx_empty = {2{~rst_n | io_stop_state}} | (~tx_full_r & ~cts); // RULE_11 RULE_12 RULE_10

    // Ch0 carrier edge; status read clears
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            carrier_prev_r <= 1'b0;
            carrier_rise_r <= 1'b0;
        end else begin
            carrier_prev_r <= carrier_detect_ch0;
            if (carrier_detect_ch0 && !carrier_prev_r) begin
                carrier_rise_r <= 1'b1; // RULE_09
            end else if (ar_fire && ar_idx == IDX_CH0_STATUS) begin
                carrier_rise_r <= 1'b0;
            end
        end
    end

    // Channel requests
    for (genvar c = 0; c < 2; c++) begin : g_req
        wire rx_any = flags[c].rx_full | flags[c].overrun | flags[c].parity_error | flags[c].framing_error;
        wire rx_req = rx_ie_r[c] & (rx_any | ((c == 0) & carrier_rise_r)); // RULE_08 RULE_09
        wire tx_req = tx_ie_r[c] & tx_empty[c]; // RULE_13
        assign chan_irq[c] = rx_req | tx_req; // RULE_18
    end

    // Sticky; live request beats clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= IRQ_RESET;
            irq_en_r   <= IRQ_RESET;
        end else begin
            irq_stat_r <= (irq_stat_r & ~({2{wr_irq_clr}} & wdata_r[1:0])) | chan_irq;
            if (wr_irq_en) begin
                irq_en_r <= wdata_r[1:0];
            end
        end
    end

    assign irq = |(irq_stat_r & irq_en_r);

    // Register read images
    for (genvar c = 0; c < 2; c++) begin : g_img
        wire pin_bit = (c == 0) ? carrier_detect_ch0 : cts_sel_r; // RULE_17
        assign status_rd[c] = {flags[c].rx_full, flags[c].overrun, flags[c].parity_error,
                               flags[c].framing_error, rx_ie_r[c], pin_bit, tx_empty[c], tx_ie_r[c]};
        assign ctrl_rd[c]   = {mp_en_r[c], rx_en_r[c], 2'b00, mp_en_r[c] & mp_bit[c], 1'b0,
                               parity_en_r[c], 1'b0}; // RULE_15
    end

    always_comb begin
        rd_val = 8'h00;
        rd_hit = 1'b1;
        if (ar_idx == IDX_CH0_CTRL) begin
            rd_val = ctrl_rd[0];
        end else if (ar_idx == IDX_CH1_CTRL) begin
            rd_val = ctrl_rd[1];
        end else if (ar_idx == IDX_CH0_STATUS) begin
            rd_val = status_rd[0];
        end else if (ar_idx == IDX_CH1_STATUS) begin
            rd_val = status_rd[1];
        end else if (ar_idx == IDX_CH0_TX) begin
            rd_val = tx_hold_r[0];
        end else if (ar_idx == IDX_CH1_TX) begin
            rd_val = tx_hold_r[1];
        end else if (ar_idx == IDX_CH0_RX) begin
            rd_val = rx_data[0];
        end else if (ar_idx == IDX_CH1_RX) begin
            rd_val = rx_data[1];
        end else if (ar_idx == IDX_IRQ_STATUS) begin
            rd_val = {6'h00, irq_stat_r};
        end else if (ar_idx == IDX_IRQ_ENABLE) begin
            rd_val = {6'h00, irq_en_r};
        end else if (ar_idx == IDX_IRQ_CLEAR) begin
            rd_val = 8'h00;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 8'h00;
            rresp_r  <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_val;
            rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule : async_serial_status_irq

//--- async_serial_status_irq_checker.sv
// Port assertions for the serial status block.
// Assumes one clock domain.
`timescale 1ns/1ps
module async_serial_status_irq_checker
    import serial_status_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_bvalid,
    input wire logic [1:0]        tx_take,
    input wire logic [1:0]        tx_valid,
    input wire logic              carrier_detect_ch0,
    input wire logic              ch0_clear_to_send_input,
    input wire logic              shared_pin_in,
    input wire logic              clocked_serial_rx_pin,
    input wire logic              ch1_clear_to_send_input,
    input wire logic              io_stop_state,
    input wire logic [1:0]        chan_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_rd(idx);
        s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == idx;
    endsequence
    // High on two edges: clear has landed
    sequence s_hi(sig);
        $past(sig) && sig;
    endsequence

    a_carrier_flush: assert property (s_rd(IDX_CH0_STATUS) ##0 s_hi(carrier_detect_ch0)
        |=> !s_axi_rdata[7:4]) else $error("carrier flush");
    a_stop_flush: assert property (s_rd(IDX_CH1_STATUS) ##0 s_hi(io_stop_state)
        |=> !s_axi_rdata[7:4] && s_axi_rdata[1]) else $error("stop flush");
    a_carrier_level: assert property (s_rd(IDX_CH0_STATUS)
        |=> s_axi_rdata[2] == $past(carrier_detect_ch0)) else $error("carrier bit");
    a_cts_empty_read: assert property (s_rd(IDX_CH0_STATUS) ##0 ch0_clear_to_send_input && !io_stop_state
        |=> !s_axi_rdata[1]) else $error("cts empty");
    a_cts_blocks_tx0: assert property (ch0_clear_to_send_input |-> !tx_valid[0])
        else $error("cts0 block");
    a_cts_blocks_tx1: assert property (ch1_clear_to_send_input |-> !tx_valid[1])
        else $error("ch1_clear_to_send_input block");
    a_stop_tx_idle: assert property (io_stop_state |=> tx_valid == 2'h0)
        else $error("stop tx");
    a_take_empties: assert property (tx_take[0] && tx_valid[0]
        |=> !tx_valid[0] || $rose(s_axi_bvalid)) else $error("take");
    a_pin_route: assert property (ch1_clear_to_send_input |-> shared_pin_in && clocked_serial_rx_pin)
        else $error("pin route");
    a_reset_quiet: assert property ($rose(rst_n) |-> chan_irq == 2'h0)
        else $error("reset irq");
endmodule : async_serial_status_irq_checker

bind async_serial_status_irq async_serial_status_irq_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

//--- serial_link_model.sv
// Far-side serial peer.
// Assumes the bench drives stall.
`timescale 1ns/1ps
module serial_link_model
    import serial_status_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       stall,
    input  wire logic [1:0] tx_valid,
    output rx_event_t [1:0] rx_ev,
    output logic [1:0]      tx_take
);
    initial rx_ev = '0;
    // Stall models a busy peer
    assign tx_take = tx_valid & {2{~stall}};

    // Inverted idle payload exposes stale use
    task automatic send(input int c, input logic [7:0] d, input logic pb, sb, mp);
        @(posedge clk);
        rx_ev[c] <= '{1'b1, d, pb, sb, mp};
        @(posedge clk);
        rx_ev[c] <= '{1'b0, ~d, ~pb, ~sb, ~mp};
    endtask : send
endmodule : serial_link_model

//--- tb_async_serial_status_irq.sv
// Bench for the serial status block.
// Assumes the link model as far side.
`timescale 1ns/1ps
module tb_async_serial_status_irq;
    import serial_status_pkg::*;
    logic            clk = 0, rst_n = 0, stall = 0, irq;
    logic [11:0]     s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]     s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]      s_axi_wstrb = 4'hf;
    logic            s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]      s_axi_bresp, s_axi_rresp, tx_take, tx_valid, chan_irq;
    logic [7:0]      tx_data_ch0, tx_data_ch1;
    logic            carrier_detect_ch0 = 0, ch0_clear_to_send_input = 0, shared_pin_in = 0, io_stop_state = 0;
    logic            clocked_serial_rx_pin, ch1_clear_to_send_input;
    rx_event_t [1:0] rx_ev;
    int              n_mismatch = 0, checks = 0;

    always #12.5 clk = ~clk;
    async_serial_status_irq #(.ADDR_W(12)) u_async_serial_status_irq (.*);
    serial_link_model u_serial_link_model (.*);

    task automatic chk_sig(input string n, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk_sig
    task automatic settle;
        repeat (2) @(negedge clk);
    endtask : settle
    task automatic wr(input logic [7:0] i, d, input logic [1:0] er = RESP_OKAY);
        @(posedge clk);
        s_axi_awaddr <= {2'b00, i, 2'b00};
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        fork
            begin do @(negedge clk); while (!s_axi_awready); @(posedge clk); s_axi_awvalid <= 0; end
            begin do @(negedge clk); while (!s_axi_wready); @(posedge clk); s_axi_wvalid <= 0; end
        join
        do @(negedge clk); while (!s_axi_bvalid);
        chk_sig("bresp", 8'(er), 8'(s_axi_bresp));
        @(posedge clk);
        s_axi_bready <= 0;
        @(negedge clk);
    endtask : wr
    task automatic chk_reg(input logic [7:0] i, e);
        @(posedge clk);
        s_axi_araddr <= {2'b00, i, 2'b00};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(negedge clk); while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 0;
        do @(negedge clk); while (!s_axi_rvalid);
        chk_sig($sformatf("reg %h", i), e, s_axi_rdata[7:0]);
        chk_sig("rresp", 8'(RESP_OKAY), 8'(s_axi_rresp));
        @(posedge clk);
        s_axi_rready <= 0;
        @(negedge clk);
    endtask : chk_reg
    task automatic send(input int c, input logic [7:0] d, input logic pb, sb, mp);
        u_serial_link_model.send(c, d, pb, sb, mp);
    endtask : send

    task automatic t_rx;
        wr(IDX_CH0_STATUS, 8'h00);
        chk_reg(IDX_CH0_STATUS, 8'h02);
        wr(8'h0d, 8'hff, RESP_SLVERR);
        wr(IDX_CH0_CTRL, 8'h42);
        send(0, 8'ha5, 1, 0, 0);
        chk_reg(IDX_CH0_STATUS, 8'hb2);
        chk_reg(IDX_CH0_RX, 8'ha5);
        chk_reg(IDX_CH0_STATUS, 8'h32);
        wr(IDX_CH0_CTRL, 8'h42);
        chk_reg(IDX_CH0_STATUS, 8'h02);
        send(0, 8'h11, 0, 1, 0);
        send(0, 8'h22, 0, 1, 0);
        chk_reg(IDX_CH0_STATUS, 8'hc2);
        chk_reg(IDX_CH0_RX, 8'h11);
        wr(IDX_CH0_CTRL, 8'h40);
        send(0, 8'h33, 1, 1, 0);
        chk_reg(IDX_CH0_STATUS, 8'h82);
        wr(IDX_CH0_CTRL, 8'h00);
        send(0, 8'h44, 0, 0, 0);
        chk_reg(IDX_CH0_STATUS, 8'h82);
        chk_reg(IDX_CH0_RX, 8'h33);
        wr(IDX_CH0_CTRL, 8'hc0);
        send(0, 8'h55, 0, 1, 1);
        chk_reg(IDX_CH0_CTRL, 8'hc8);
        chk_reg(IDX_CH0_RX, 8'h55);
        $display("t_rx done");
    endtask : t_rx

    task automatic t_irq;
        wr(IDX_CH0_STATUS, 8'h08);
        wr(IDX_IRQ_ENABLE, 8'h01);
        send(0, 8'h77, 0, 1, 1);
        settle;
        chk_sig("chan_irq", 8'h01, 8'(chan_irq));
        chk_sig("irq", 8'h01, 8'(irq));
        wr(IDX_IRQ_ENABLE, 8'h00);
        chk_sig("irq", 8'h00, 8'(irq));
        chk_reg(IDX_IRQ_STATUS, 8'h01);
        chk_reg(IDX_CH0_RX, 8'h77);
        wr(IDX_IRQ_CLEAR, 8'h01);
        wr(IDX_IRQ_ENABLE, 8'h01);
        chk_sig("irq", 8'h00, 8'(irq));
        chk_sig("chan_irq", 8'h00, 8'(chan_irq));
        @(posedge clk);
        carrier_detect_ch0 <= 1;
        settle;
        chk_sig("chan_irq", 8'h01, 8'(chan_irq));
        chk_reg(IDX_CH0_STATUS, 8'h0e);
        chk_sig("chan_irq", 8'h00, 8'(chan_irq));
        @(posedge clk);
        carrier_detect_ch0 <= 0;
        wr(IDX_CH0_STATUS, 8'h04);
        chk_reg(IDX_CH0_STATUS, 8'h02);
        $display("t_irq done");
    endtask : t_irq

    task automatic t_tx;
        wr(IDX_CH1_STATUS, 8'h05);
        chk_sig("chan_irq", 8'h02, 8'(chan_irq));
        @(posedge clk);
        stall <= 1;
        wr(IDX_CH1_TX, 8'h5a);
        chk_sig("tx_valid", 8'h02, 8'(tx_valid));
        chk_sig("tx_data", 8'h5a, tx_data_ch1);
        chk_reg(IDX_CH1_STATUS, 8'h05);
        @(posedge clk);
        stall <= 0;
        settle;
        chk_reg(IDX_CH1_STATUS, 8'h07);
        @(posedge clk);
        ch0_clear_to_send_input <= 1;
        wr(IDX_CH0_TX, 8'hc3);
        chk_sig("tx_valid", 8'h00, 8'(tx_valid));
        chk_sig("tx_data0", 8'hc3, tx_data_ch0);
        chk_reg(IDX_CH0_STATUS, 8'h00);
        @(posedge clk);
        ch0_clear_to_send_input <= 0;
        shared_pin_in <= 1;
        settle;
        chk_sig("ch1_clear_to_send_input", 8'h01, 8'(ch1_clear_to_send_input));
        chk_reg(IDX_CH1_STATUS, 8'h05);
        wr(IDX_CH1_STATUS, 8'h01);
        chk_sig("ch1_clear_to_send_input", 8'h00, 8'(ch1_clear_to_send_input));
        @(posedge clk);
        shared_pin_in <= 0;
        settle;
        chk_sig("csi_rx", 8'h00, 8'(clocked_serial_rx_pin));
        wr(IDX_CH0_CTRL, 8'h40);
        send(0, 8'h99, 0, 0, 0);
        @(posedge clk);
        io_stop_state <= 1;
        settle;
        chk_reg(IDX_CH0_STATUS, 8'h02);
        chk_reg(IDX_CH1_STATUS, 8'h03);
        $display("t_tx done");
    endtask : t_tx

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    initial begin
        #200000;
        n_mismatch++;
        stop_test;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        t_rx;
        t_irq;
        t_tx;
        stop_test;
    end
endmodule : tb_async_serial_status_irq
